// file: rtl/ptw_map.svh
`ifndef PTW_MAP_SVH
`define PTW_MAP_SVH

// Register offsets on the register port.
`define PTW_REG_CTRL 8'h00
`define PTW_REG_SROOT 8'h04
`define PTW_REG_UROOT 8'h08
`define PTW_REG_STATUS 8'h0C
`define PTW_REG_COUNT 8'h10

// Control and status bit positions and register reset values.
`define PTW_CTRL_PG4K 0
`define PTW_CTRL_EN 1
`define PTW_ST_BUSY 0
`define PTW_ST_FAULT 1
`define PTW_ST_BERR 2
`define PTW_CTRL_RST 2'h0
`define PTW_ROOT_RST 32'h0000_0000
`define PTW_ROOT_LO 9

// Descriptor fields.
`define PTW_D_TYPE 1:0
`define PTW_D_UDT_RES 1
`define PTW_D_W 2
`define PTW_D_U 3
`define PTW_D_M 4
`define PTW_D_S 7
`define PTW_PDT_RES 2'h1
`define PTW_PDT_IND 2'h2

// Walk levels.
`define PTW_LV_L1 2'h0
`define PTW_LV_L2 2'h1
`define PTW_LV_PG 2'h2
`define PTW_LV_IND 2'h3

// Address fields of table pointers and of the logical address.
`define PTW_TA_HI 31:9
`define PTW_PT8K_HI 31:7
`define PTW_PT4K_HI 31:8
`define PTW_IND_HI 31:2
`define PTW_TIA 31:25
`define PTW_TIB 24:18
`define PTW_TIC8K 17:13
`define PTW_TIC4K 17:12
`define PTW_PF_HI 31:13
`define PTW_PF_B4K 12
`define PTW_PAGE_HI 31:12

`endif

// file: rtl/ptw_pkg.sv
`default_nettype none
package ptw_pkg;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_READ  = 9'h002,
        ST_EVAL  = 9'h004,
        ST_WRITE = 9'h008,
        ST_LRD   = 9'h010,
        ST_LWR   = 9'h020,
        ST_NEXT  = 9'h040,
        ST_FILL  = 9'h080,
        ST_WAIT  = 9'h100
    } ptw_state_e;

    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_WR   = 2'h1,
        ACT_RMW  = 2'h2
    } ptw_act_e;

    typedef logic [1:0] ptw_level_t;

endpackage
`default_nettype wire

// file: rtl/ptw_eval_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ptw_eval_if;
    logic [31:0] desc;
    ptw_pkg::ptw_level_t level;
    logic wp_acc;
    logic priv;
    logic write;
    logic ok;
    logic indirect;
    logic wp;
    logic sup_viol;
    logic set_m;
    ptw_pkg::ptw_act_e act;
    logic [31:0] new_desc;

    modport walker(output desc, level, wp_acc, priv, write,
                   input ok, indirect, wp, sup_viol, set_m, act, new_desc);
    modport eval(input desc, level, wp_acc, priv, write,
                 output ok, indirect, wp, sup_viol, set_m, act, new_desc);
endinterface

`default_nettype wire

// file: rtl/ptw_desc_eval.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptw_map.svh"

module ptw_desc_eval (
    // Descriptor decode.
    ptw_eval_if.eval ev
);
    import ptw_pkg::*;

    logic table_lv;
    logic u_bit;
    logic m_bit;

    always_comb begin
        table_lv = (ev.level == `PTW_LV_L1) || (ev.level == `PTW_LV_L2);
        u_bit = ev.desc[`PTW_D_U];
        m_bit = ev.desc[`PTW_D_M];
        ev.indirect = (ev.level == `PTW_LV_PG) && (ev.desc[`PTW_D_TYPE] == `PTW_PDT_IND);
        ev.wp = ev.wp_acc | (ev.desc[`PTW_D_W] && !ev.indirect);
        ev.sup_viol = !table_lv && !ev.indirect && ev.desc[`PTW_D_S] && !ev.priv;
        if (table_lv) begin
            ev.ok = ev.desc[`PTW_D_UDT_RES];
        end else begin
            ev.ok = (ev.desc[`PTW_D_TYPE] == `PTW_PDT_RES) || ev.indirect;
        end
        ev.set_m = !table_lv && !ev.indirect && ev.write && !m_bit && !ev.wp && !ev.sup_viol;
        if (!ev.ok) begin
            ev.act = ACT_NONE;
        end else if (table_lv) begin
            ev.act = u_bit ? ACT_NONE : ACT_WR;
        end else if (ev.indirect) begin
            ev.act = ACT_NONE;
        end else if (!u_bit && !ev.set_m) begin
            ev.act = ACT_RMW;
        end else if (ev.set_m) begin
            ev.act = ACT_WR;
        end else begin
            ev.act = ACT_NONE;
        end
        ev.new_desc = ev.desc;
        ev.new_desc[`PTW_D_U] = 1'b1;
        ev.new_desc[`PTW_D_M] = m_bit | ev.set_m;
    end

endmodule

`default_nettype wire

// file: rtl/ptw_walker.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ptw_map.svh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module ptw_walker #(
    parameter int COUNT_W = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Miss request from the translation cache.
    input wire logic miss_valid,
    input wire logic [31:0] miss_la,
    input wire logic miss_privilege_code_bit,
    input wire logic miss_write,
    output logic walk_busy,
    output logic retry,
    // Descriptor memory bus.
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_we,
    output logic [31:0] mem_wdata,
    output logic mem_lock,
    output logic mem_cacheable,
    output logic mem_push_inval,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    // Translation cache fill.
    output logic tc_fill,
    output logic [19:0] tc_fill_la,
    output logic [19:0] tc_fill_pa,
    output logic tc_fill_resident,
    output logic tc_fill_wp,
    output logic tc_fill_sup,
    output logic tc_fill_mod,
    output logic tc_fill_berr,
    // Retried lookup and forwarding.
    input wire logic tc_hit,
    input wire logic [31:0] tc_hit_pa,
    input wire logic tc_hit_ok,
    output logic fwd_valid,
    output logic [31:0] fwd_pa,
    output logic exc_valid
);
    import ptw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and descriptor evaluator.

    ptw_state_e state_q;
    ptw_level_t level_q;
    logic [1:0] ctrl_q;
    logic [31:0] sroot_q;
    logic [31:0] uroot_q;
    logic [31:0] la_q;
    logic priv_q;
    logic write_q;
    logic [31:0] desc_q;
    logic wp_q;
    logic setm_q;
    logic supv_q;
    logic fault_q;
    logic berr_q;
    logic last_fault_q;
    logic last_berr_q;
    logic [COUNT_W-1:0] count_q;
    logic [31:0] reg_rdata_q;
    logic walk_busy_q;
    logic retry_q;
    logic mem_req_q;
    logic [31:0] mem_addr_q;
    logic mem_we_q;
    logic [31:0] mem_wdata_q;
    logic mem_lock_q;
    logic mem_cacheable_q;
    logic mem_push_inval_q;
    logic tc_fill_q;
    logic [19:0] tc_fill_la_q;
    logic [19:0] tc_fill_pa_q;
    logic tc_fill_resident_q;
    logic tc_fill_wp_q;
    logic tc_fill_sup_q;
    logic tc_fill_mod_q;
    logic tc_fill_berr_q;
    logic fwd_valid_q;
    logic [31:0] fwd_pa_q;
    logic exc_valid_q;
    logic [6:0] tia_in;
    logic [6:0] tib_q;
    logic [31:0] root_sel;
    logic [31:0] page_addr;

    ptw_eval_if ev ();

    ptw_desc_eval u_eval (
        .ev(ev)
    );

    assign ev.desc = desc_q;
    assign ev.level = level_q;
    assign ev.wp_acc = wp_q;
    assign ev.priv = priv_q;
    assign ev.write = write_q;

    assign tia_in = miss_la[`PTW_TIA];
    assign tib_q = la_q[`PTW_TIB];
    assign root_sel = miss_privilege_code_bit ? sroot_q : uroot_q;
    assign page_addr = ctrl_q[`PTW_CTRL_PG4K] ?
        {desc_q[`PTW_PT4K_HI], la_q[`PTW_TIC4K], 2'h0} :
        {desc_q[`PTW_PT8K_HI], la_q[`PTW_TIC8K], 2'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Register port.

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= `PTW_CTRL_RST;
            sroot_q <= `PTW_ROOT_RST;
            uroot_q <= `PTW_ROOT_RST;
        end else if (reg_wr) begin
            if (reg_addr == `PTW_REG_CTRL) begin
                ctrl_q <= reg_wdata[1:0];
            end
            if (reg_addr == `PTW_REG_SROOT) begin
                sroot_q <= {reg_wdata[`PTW_TA_HI], 9'h000};
            end
            if (reg_addr == `PTW_REG_UROOT) begin
                uroot_q <= {reg_wdata[`PTW_TA_HI], 9'h000};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `PTW_REG_CTRL: reg_rdata_q <= {30'h0, ctrl_q};
                `PTW_REG_SROOT: reg_rdata_q <= sroot_q;
                `PTW_REG_UROOT: reg_rdata_q <= uroot_q;
                `PTW_REG_STATUS: reg_rdata_q <= {29'h0, last_berr_q, last_fault_q, walk_busy_q};
                `PTW_REG_COUNT: reg_rdata_q <= 32'(count_q);
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

    // Walk statistics: last outcome and number of completed walks.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_fault_q <= 1'b0;
            last_berr_q <= 1'b0;
            count_q <= '0;
        end else if (tc_fill_q) begin
            last_fault_q <= !tc_fill_resident_q;
            last_berr_q <= tc_fill_berr_q;
            count_q <= count_q + COUNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Walk sequencer.

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            level_q <= `PTW_LV_L1;
            la_q <= 32'h0000_0000;
            priv_q <= 1'b0;
            write_q <= 1'b0;
            desc_q <= 32'h0000_0000;
            wp_q <= 1'b0;
            setm_q <= 1'b0;
            supv_q <= 1'b0;
            fault_q <= 1'b0;
            berr_q <= 1'b0;
            walk_busy_q <= 1'b0;
            retry_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_we_q <= 1'b0;
            mem_wdata_q <= 32'h0000_0000;
            mem_lock_q <= 1'b0;
            mem_cacheable_q <= 1'b1;
            mem_push_inval_q <= 1'b0;
            tc_fill_q <= 1'b0;
            tc_fill_la_q <= 20'h00000;
            tc_fill_pa_q <= 20'h00000;
            tc_fill_resident_q <= 1'b0;
            tc_fill_wp_q <= 1'b0;
            tc_fill_sup_q <= 1'b0;
            tc_fill_mod_q <= 1'b0;
            tc_fill_berr_q <= 1'b0;
            fwd_valid_q <= 1'b0;
            fwd_pa_q <= 32'h0000_0000;
            exc_valid_q <= 1'b0;
        end else begin
            tc_fill_q <= 1'b0;
            retry_q <= 1'b0;
            fwd_valid_q <= 1'b0;
            exc_valid_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (miss_valid && ctrl_q[`PTW_CTRL_EN]) begin
                        walk_busy_q <= 1'b1;
                        la_q <= miss_la;
                        priv_q <= miss_privilege_code_bit;
                        write_q <= miss_write;
                        level_q <= `PTW_LV_L1;
                        wp_q <= 1'b0;
                        setm_q <= 1'b0;
                        supv_q <= 1'b0;
                        fault_q <= 1'b0;
                        berr_q <= 1'b0;
                        mem_addr_q <= {root_sel[`PTW_TA_HI], tia_in, 2'h0};
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_cacheable_q <= 1'b1;
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (mem_err) begin
                        mem_req_q <= 1'b0;
                        fault_q <= 1'b1;
                        berr_q <= 1'b1;
                        state_q <= ST_FILL;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        desc_q <= mem_rdata;
                        state_q <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    if (!ev.ok) begin
                        fault_q <= 1'b1;
                        berr_q <= 1'b1;
                        state_q <= ST_FILL;
                    end else begin
                        wp_q <= ev.wp;
                        setm_q <= ev.set_m;
                        supv_q <= ev.sup_viol;
                        unique case (ev.act)
                            ACT_WR: begin
                                mem_req_q <= 1'b1;
                                mem_we_q <= 1'b1;
                                mem_wdata_q <= ev.new_desc;
                                state_q <= ST_WRITE;
                            end
                            ACT_RMW: begin
                                mem_req_q <= 1'b1;
                                mem_we_q <= 1'b0;
                                mem_lock_q <= 1'b1;
                                mem_cacheable_q <= 1'b0;
                                mem_push_inval_q <= 1'b1;
                                state_q <= ST_LRD;
                            end
                            default: begin
                                state_q <= ST_NEXT;
                            end
                        endcase
                    end
                end
                ST_WRITE: begin
                    if (mem_ack || mem_err) begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        desc_q <= mem_wdata_q;
                        fault_q <= mem_err;
                        berr_q <= mem_err;
                        state_q <= mem_err ? ST_FILL : ST_NEXT;
                    end
                end
                ST_LRD: begin
                    if (mem_err) begin
                        mem_req_q <= 1'b0;
                        mem_lock_q <= 1'b0;
                        mem_cacheable_q <= 1'b1;
                        mem_push_inval_q <= 1'b0;
                        fault_q <= 1'b1;
                        berr_q <= 1'b1;
                        state_q <= ST_FILL;
                    end else if (mem_ack) begin
                        mem_we_q <= 1'b1;
                        mem_wdata_q <= mem_rdata | (32'h1 << `PTW_D_U) | (32'(setm_q) << `PTW_D_M);
                        state_q <= ST_LWR;
                    end
                end
                ST_LWR: begin
                    if (mem_ack || mem_err) begin
                        mem_req_q <= 1'b0;
                        mem_we_q <= 1'b0;
                        mem_lock_q <= 1'b0;
                        mem_cacheable_q <= 1'b1;
                        mem_push_inval_q <= 1'b0;
                        desc_q <= mem_wdata_q;
                        fault_q <= mem_err;
                        berr_q <= mem_err;
                        state_q <= mem_err ? ST_FILL : ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (level_q == `PTW_LV_L1) begin
                        mem_addr_q <= {desc_q[`PTW_TA_HI], tib_q, 2'h0};
                        level_q <= `PTW_LV_L2;
                        mem_req_q <= 1'b1;
                        state_q <= ST_READ;
                    end else if (level_q == `PTW_LV_L2) begin
                        mem_addr_q <= page_addr;
                        level_q <= `PTW_LV_PG;
                        mem_req_q <= 1'b1;
                        state_q <= ST_READ;
                    end else if (level_q == `PTW_LV_PG && desc_q[`PTW_D_TYPE] == `PTW_PDT_IND) begin
                        mem_addr_q <= {desc_q[`PTW_IND_HI], 2'h0};
                        level_q <= `PTW_LV_IND;
                        mem_req_q <= 1'b1;
                        state_q <= ST_READ;
                    end else begin
                        state_q <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    tc_fill_q <= 1'b1;
                    retry_q <= 1'b1;
                    tc_fill_la_q <= la_q[`PTW_PAGE_HI];
                    tc_fill_pa_q <= {desc_q[`PTW_PF_HI],
                                     ctrl_q[`PTW_CTRL_PG4K] & desc_q[`PTW_PF_B4K]};
                    tc_fill_resident_q <= !fault_q && !supv_q;
                    tc_fill_wp_q <= wp_q;
                    tc_fill_sup_q <= !fault_q && desc_q[`PTW_D_S];
                    tc_fill_mod_q <= !fault_q && desc_q[`PTW_D_M];
                    tc_fill_berr_q <= berr_q;
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (tc_hit) begin
                        fwd_valid_q <= tc_hit_ok;
                        fwd_pa_q <= tc_hit_pa;
                        exc_valid_q <= !tc_hit_ok;
                        walk_busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign walk_busy = walk_busy_q;
    assign retry = retry_q;
    assign mem_req = mem_req_q;
    assign mem_addr = mem_addr_q;
    assign mem_we = mem_we_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_lock = mem_lock_q;
    assign mem_cacheable = mem_cacheable_q;
    assign mem_push_inval = mem_push_inval_q;
    assign tc_fill = tc_fill_q;
    assign tc_fill_la = tc_fill_la_q;
    assign tc_fill_pa = tc_fill_pa_q;
    assign tc_fill_resident = tc_fill_resident_q;
    assign tc_fill_wp = tc_fill_wp_q;
    assign tc_fill_sup = tc_fill_sup_q;
    assign tc_fill_mod = tc_fill_mod_q;
    assign tc_fill_berr = tc_fill_berr_q;
    assign fwd_valid = fwd_valid_q;
    assign fwd_pa = fwd_pa_q;
    assign exc_valid = exc_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_busy_walk: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q != ST_IDLE) |-> walk_busy_q) else $error("Walk active while busy is low.");

    a_root_first: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_IDLE && miss_valid && ctrl_q[`PTW_CTRL_EN]) |=>
        (mem_addr_q == (($past(miss_privilege_code_bit) ? $past(sroot_q) : $past(uroot_q))
                        | {23'h0, $past(tia_in), 2'h0}))) else $error("First descriptor address wrong.");

    a_second_addr: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_NEXT && level_q == `PTW_LV_L1) |=>
        (mem_addr_q == {$past(desc_q) & 32'hFFFF_FE00} + {23'h0, $past(tib_q), 2'h0})
        && mem_req_q) else $error("Second descriptor address wrong.");

    a_lock_rmw: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_lock_q |-> (state_q == ST_LRD || state_q == ST_LWR)) else $error("Lock outside locked cycle.");

    a_rmw_nocache: assert property (@(posedge mclk) disable iff (!rst_n)
        mem_lock_q |-> (!mem_cacheable_q && mem_push_inval_q)) else $error("Locked access is cacheable.");

    a_plain_cache: assert property (@(posedge mclk) disable iff (!rst_n)
        (mem_req_q && !mem_lock_q) |-> (mem_cacheable_q && !mem_push_inval_q))
        else $error("Plain access not cacheable.");

    a_used_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (mem_req_q && mem_we_q) |-> mem_wdata_q[`PTW_D_U]) else $error("Descriptor write without used flag.");

    a_err_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_READ && mem_err) |=> ##1 (tc_fill_q && !tc_fill_resident_q && tc_fill_berr_q))
        else $error("Transfer error did not fill a faulting entry.");

    a_retry_fill: assert property (@(posedge mclk) disable iff (!rst_n)
        tc_fill_q |-> (retry_q && state_q == ST_WAIT)) else $error("Fill without retry.");

    a_fwd_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_WAIT && tc_hit && tc_hit_ok) |=>
        (fwd_valid_q && fwd_pa_q == $past(tc_hit_pa) && !exc_valid_q)) else $error("Clean hit not forwarded.");

endmodule

`default_nettype wire

// file: tb/ptw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptw_mem_model (
    // Walker bus.
    input wire logic mclk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic err_en,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    // Answer.
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [2:0] dly = 3'h0;
    initial {mem_ack, mem_err, mem_rdata} = '0;
    // Each answer sets the delay of the next; read data toggle when not valid.
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack && !mem_err && dly != 3'h0) begin
            dly <= dly - 3'h1;
        end else if (mem_req && !mem_ack && !mem_err) begin
            dly <= mem_addr[4:2];
            mem_err <= err_en;
            mem_ack <= !err_en;
            if (!mem_we) begin
                mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
            end else if (!err_en) begin
                mem[mem_addr] = mem_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/page_table_walker_bench.sv
`timescale 1ns/1ps
`default_nettype none
module page_table_walker_bench;
    logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, miss_valid = 0, miss_privilege_code_bit = 0;
    logic miss_write = 0, tc_hit = 0, tc_hit_ok = 0, err_en = 0, walk_busy, retry, mem_req, mem_we, mem_lock;
    logic mem_cacheable, mem_push_inval, mem_ack, mem_err, tc_fill, tc_fill_resident, tc_fill_wp, tc_fill_sup;
    logic tc_fill_mod, tc_fill_berr, fwd_valid, exc_valid;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, miss_la = 0, tc_hit_pa = 0, reg_rdata, mem_addr, mem_wdata, mem_rdata, fwd_pa, q;
    logic [19:0] tc_fill_la, tc_fill_pa;
    logic [15:0] rs = 16'hCD2C;
    int fails = 0, samples_checked = 0;
    ptw_walker u_dut (.*);
    ptw_mem_model u_mem (.*);
    initial forever #10 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function automatic void rn(output logic [31:0] r);
        rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
        r = {rs, rs ^ 16'hA5C3};
    endfunction
    function automatic logic [31:0] pga(input logic [31:0] la, input logic k4);
        return 32'h4000 | (k4 ? {24'h0, la[17:12], 2'h0} : {25'h0, la[17:13], 2'h0});
    endfunction
    task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
        @(posedge mclk);
    endtask
    task automatic run(input logic p, w, k4, ind, bad, er);
        logic [31:0] la, r, a1, a3, d1, pd, pg;
        logic wp, sv, m;
        int n;
        rn(la);
        rn(r);
        a1 = (p ? 32'h1000 : 32'h2000) | {23'h0, la[31:25], 2'h0};
        a3 = pga(la, k4);
        d1 = bad && !ind ? r & 32'hFFFF_FFFD : 32'h3002 | {28'h0, r[3:2], 2'h0};
        pd = r & 32'hFFFF_F09C | (bad ? 32'h2 : 32'h1);
        u_mem.mem[a1] = d1;
        u_mem.mem[32'h3000 | {23'h0, la[24:18], 2'h0}] = 32'h4002 | {28'h0, r[5:4], 2'h0};
        u_mem.mem[a3] = ind ? 32'h5002 : pd;
        u_mem.mem[32'h5000] = pd;
        wp = d1[2] | r[4] | pd[2];
        sv = pd[7] & !p;
        m = pd[4] | w & !wp & !sv;
        pg = ind ? 32'h5000 : a3;
        @(posedge mclk);
        miss_valid <= 1'b1;
        miss_privilege_code_bit <= p;
        miss_write <= w;
        miss_la <= la;
        err_en <= er;
        @(posedge mclk);
        miss_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (tc_fill !== 1'b1 && n < 400);
        chk("pulse", {tc_fill, retry}, 2'b11);
        chk("fill", {tc_fill_resident, tc_fill_berr}, {!(bad | er | sv), bad | er});
        chk("la", tc_fill_la, la[31:12]);
        if (!(bad | er)) chk("map", {tc_fill_wp, tc_fill_pa}, {wp, pd[31:13], k4 & pd[12]});
        if (!(bad | er)) chk("page", {tc_fill_sup, tc_fill_mod}, {pd[7], m});
        if (bad) chk("keep", u_mem.mem[ind ? 32'h5000 : a1], ind ? pd : d1);
        else if (!er) chk("flags", {u_mem.mem[a1][3], u_mem.mem[pg][4:3]}, {1'b1, m, 1'b1});
        @(posedge mclk);
        tc_hit <= 1'b1;
        tc_hit_pa <= r;
        tc_hit_ok <= r[8];
        @(posedge mclk);
        tc_hit <= 1'b0;
        #1 chk("fwd", {fwd_valid, exc_valid, walk_busy}, {r[8], !r[8], 1'b0});
        if (r[8]) chk("pa", fwd_pa, r);
        @(posedge mclk);
        rg(0, 8'h0C, 32'h0);
        chk("status", q[2:0], {bad | er, bad | er | sv, 1'b0});
    endtask
    always @(posedge mclk) begin
        if (rst_n && mem_req) chk("bus", {mem_cacheable, mem_push_inval}, {!mem_lock, mem_lock});
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rg(1, 8'h04, 32'h0000_11FF);
        rg(1, 8'h08, 32'h0000_2000);
        rg(0, 8'h04, 32'h0);
        chk("root", q, 32'h1000);
        rg(0, 8'h14, 32'h0);
        chk("unmapped", q, 32'h0);
        for (int i = 0; i < 48; i++) begin
            rg(1, 8'h00, {30'h0, 1'b1, i[1]});
            run(i[0], i[2], i[1], i[3], i % 5 == 4, i % 7 == 6);
            $display("walk %0d done", i);
        end
        rg(0, 8'h10, 32'h0);
        chk("count", q, 32'h0000_0030);
        summarize();
    end
endmodule
`default_nettype wire
